// >>> pudma_bus_mdl.sv
// Purpose: bus-side partner: arbiter, memory and interrupt taker
// Assumes: dut bus outputs are positive-true levels
// Notes:   a released data bus toggles; each read answers a fresh word
`timescale 1ns/1ps
`default_nettype none
module pudma_bus_mdl (
  input  wire logic        mclk,
  input  wire logic        mute,
  input  wire logic        bdmr,
  input  wire logic        bsack,
  input  wire logic        bsync,
  input  wire logic        bdout,
  input  wire logic        bdin_out,
  input  wire logic        brply_out,
  input  wire logic        birq,
  input  wire logic [15:0] bdal_out,
  input  wire logic        bdal_oe,
  output logic             bdmgi,
  output logic             biaki,
  output logic             bdin_in,
  output logic             brply_in,
  output logic      [15:0] bdal_in,
  output logic      [15:0] wr_data,
  output logic      [15:0] vec_seen,
  output logic      [15:0] addr_seen
);
  logic        rply    = 1'b0;
  logic        pdin    = 1'b0;
  logic        ph      = 1'b0;
  logic        din_d   = 1'b0;
  logic        gnt     = 1'b0;
  logic        iak     = 1'b0;
  logic [15:0] rd_word = 16'hc3a5;
  logic [15:0] wdat    = 16'h0000;
  logic [15:0] vec     = 16'h0000;
  logic [15:0] adr     = 16'h0000;
  // ----------------------------------------------------------------
  // wired lines
  // ----------------------------------------------------------------
  assign bdmgi     = gnt;
  assign biaki     = iak;
  assign wr_data   = wdat;
  assign vec_seen  = vec;
  assign addr_seen = adr;
  assign bdin_in   = bdin_out | pdin;
  assign brply_in  = brply_out | rply;
  assign bdal_in   = bdal_oe ? bdal_out : ((rply & bdin_out) ? rd_word : {16{ph}});
  always @(posedge mclk)
  begin
    ph <= ~ph;
    din_d <= bdin_out;
    if (bdmr)
      gnt <= 1'b1;
    if (bsack)
      gnt <= 1'b0;
    rply <= (bdout | bdin_out) & ~mute;
    if (bdout & rply)
      wdat <= bdal_out;
    // a new word per read, so a stale output buffer shows up
    if (din_d & ~bdin_out)
      rd_word <= rd_word + 16'h0001;
    if (bdal_oe & bsack & ~bsync)
      adr <= bdal_out;
    if (birq)
      pdin <= 1'b1;
    if (pdin & birq)
      iak <= 1'b1;
    if (brply_out & bdal_oe)
    begin
      vec <= bdal_out;
      pdin <= 1'b0;
      iak <= 1'b0;
    end
  end
endmodule : pudma_bus_mdl
`default_nettype wire

// >>> pudma_core.sv
// Purpose: dma bus master between a user parallel device and memory
// Assumes: bus lines as positive-true levels; pins pass 3-flop filters
// Notes:   software side is plain ports, no register bus
// How it works
// - start bit drops ready; user sets lines first
// - request latches data, cycle type, burst select
// - request sets pending, busy low, bus request
// - grant gives mastership: bsack up, request down
// - write: address and bwtbt, then bsync, held
// - then word drops bwtbt, byte keeps; data out
// - reply drops bdout, data; release after reply
// - read: address, bsync, then bdin after period
// - reply: capture data, drop bdin, then release
// - read data held until next read load
// - step address and count only when allowed
// - after transfer busy high, ready stays low
// - count reaching zero raises ready and interrupt
// - attention sets its own flag, same interrupt as completion
// - missing reply means nonexistent memory interrupt
// - all interrupt causes share one vector
// - interrupt: birq, acknowledge, vector with reply
// - acknowledge gone then reply is dropped
// - request held minimum time, only while ready low
// - attention ends transfers, sets ready, interrupts
// - burst keeps bus; single releases per request
`timescale 1ns/1ps
`default_nettype none
`include "pudma_map.svh"
module pudma_core
  import pudma_pkg::*;
#(
  parameter logic [15:0] REQ_CYC    = 16'(`PUDMA_REQ_CYC),
  parameter logic [15:0] ADDR_CYC   = 16'(`PUDMA_ADDR_CYC),
  parameter logic [15:0] NXM_CYC    = 16'(`PUDMA_NXM_CYC),
  parameter logic [15:0] INT_VECTOR = `PUDMA_VECTOR
)(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        go_start,
  input  wire logic        int_enable,
  input  wire logic        flag_clear,
  input  wire logic        wc_load,
  input  wire logic        ba_load,
  input  wire logic [15:0] load_value,
  output logic      [15:0] word_counter,
  output logic      [15:0] bus_address,
  output logic             count_done_flag,
  output logic             attention_flag,
  output logic             nxm_flag,
  input  wire logic        cycle_request,
  input  wire logic        user_attention,
  input  wire logic        addr_step_allow,
  input  wire logic        count_step_allow,
  input  wire logic        byte_sel,
  input  wire logic        burst_select_n,
  input  wire logic        cycle_type_bit0,
  input  wire logic        cycle_type_bit1,
  input  wire logic [15:0] user_data_in,
  output logic             ready,
  output logic             busy_n,
  output logic      [15:0] output_holding_reg,
  input  wire logic [15:0] bdal_in,
  output logic      [15:0] bdal_out,
  output logic             bdal_oe,
  output logic             bdmr,
  input  wire logic        bdmgi,
  output logic             bsack,
  output logic             bsync,
  output logic             bwtbt,
  output logic             bdout,
  input  wire logic        bdin_in,
  output logic             bdin_out,
  output logic             bdin_oe,
  input  wire logic        brply_in,
  output logic             brply_out,
  output logic             brply_oe,
  output logic             birq,
  input  wire logic        biaki
);
  // ----------------------------------------------------------------
  // pin filters
  // ----------------------------------------------------------------
  logic [`PUDMA_SY_W-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      flt_reg <= '0;
    end
    else
    begin
      s1_reg  <= {user_data_in, bdal_in, cycle_type_bit1, cycle_type_bit0, burst_select_n, byte_sel,
                  count_step_allow, addr_step_allow, biaki, bdin_in, brply_in, bdmgi, user_attention,
                  cycle_request};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      // a bit moves only once the last two stages agree
      flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
    end
  end
  logic        req_f, user_attention_f, gnt_f, rply_f, din_f, iak_f;
  logic [15:0] dal_f, udat_f;
  assign req_f  = flt_reg[`PUDMA_SY_REQ];
  assign user_attention_f = flt_reg[`PUDMA_SY_USER_ATTENTION];
  assign gnt_f  = flt_reg[`PUDMA_SY_GNT];
  assign rply_f = flt_reg[`PUDMA_SY_RPLY];
  assign din_f  = flt_reg[`PUDMA_SY_DIN];
  assign iak_f  = flt_reg[`PUDMA_SY_IAK];
  assign dal_f  = flt_reg[`PUDMA_SY_DAL +: 16];
  assign udat_f = flt_reg[`PUDMA_SY_UDAT +: 16];
  // ----------------------------------------------------------------
  // request qualification and latches
  // ----------------------------------------------------------------
  pudma_state_t st_reg;
  pudma_cyc_t   cyc_reg;
  logic [15:0]  req_cnt_reg, tcnt_reg, wc_reg, ba_reg, input_holding_reg_reg, output_holding_reg_reg, dal_reg;
  logic         ready_reg, busy_n_reg, burst_reg, astep_reg, cstep_reg, user_attention_d_reg;
  logic         accept, wr, byte_wr, xfer_end, done_ev, user_attention_ev, nxm_ev, rd_load, iack_take;
  logic [15:0]  wc_next;
  logic         bdal_oe_d, bdin_dma;
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !req_f)
      req_cnt_reg <= 16'h0000;
    else if (req_cnt_reg != REQ_CYC)
      req_cnt_reg <= req_cnt_reg + 16'h0001;
  end
  // one acceptance per high period, and only with ready low
  assign accept = req_f && (req_cnt_reg == REQ_CYC - 16'h0001) && !ready_reg && !user_attention_f &&
                  (st_reg == S_IDLE || st_reg == S_HOLD);
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      input_holding_reg_reg  <= 16'h0000;
      cyc_reg   <= CYC_DATI;
      burst_reg <= 1'b0;
      astep_reg <= 1'b0;
      cstep_reg <= 1'b0;
    end
    else if (accept)
    begin
      input_holding_reg_reg  <= udat_f;
      cyc_reg   <= pudma_cyc_t'({flt_reg[`PUDMA_SY_CT0], flt_reg[`PUDMA_SY_CT1]});
      burst_reg <= !flt_reg[`PUDMA_SY_BURSTN];
      astep_reg <= flt_reg[`PUDMA_SY_ASTEP];
      cstep_reg <= flt_reg[`PUDMA_SY_CSTEP];
    end
  end
  assign wr       = cyc_reg == CYC_DATO || cyc_reg == CYC_DATOB;
  assign byte_wr  = cyc_reg == CYC_DATOB;
  assign xfer_end = st_reg == S_END;
  assign wc_next  = wc_reg + 16'h0001;
  assign done_ev  = xfer_end && cstep_reg && wc_next == 16'h0000;
  assign nxm_ev   = st_reg == S_DATA && !rply_f && tcnt_reg == NXM_CYC - 16'h0001;
  assign user_attention_ev  = user_attention_f && !user_attention_d_reg;
  assign rd_load  = st_reg == S_DATA && rply_f && !wr;
  // ----------------------------------------------------------------
  // bus master sequence
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_reg     <= S_IDLE;
      tcnt_reg   <= 16'h0000;
      dal_reg    <= 16'h0000;
      bdal_oe_d  <= 1'b0;
      bdmr       <= 1'b0;
      bsack      <= 1'b0;
      bsync      <= 1'b0;
      bwtbt      <= 1'b0;
      bdout      <= 1'b0;
      bdin_dma   <= 1'b0;
      busy_n_reg <= `PUDMA_BUSY_N_RST;
    end
    else
    begin
      case (st_reg)
        S_IDLE:
          if (accept)
          begin
            st_reg     <= S_REQ;
            bdmr       <= 1'b1;
            busy_n_reg <= 1'b0;
          end
        S_REQ:
          if (gnt_f)
          begin
            st_reg <= S_GACK;
            bsack  <= 1'b1;
            bdmr   <= 1'b0;
          end
        S_GACK:
          // the grant must be gone before the cycle starts
          if (!gnt_f)
          begin
            st_reg    <= S_ADDR;
            tcnt_reg  <= 16'h0000;
            dal_reg   <= {ba_reg[15:1], flt_reg[`PUDMA_SY_BYTE]};
            bdal_oe_d <= 1'b1;
            bwtbt     <= wr;
          end
        S_ADDR:
        begin
          bsync    <= 1'b1;
          tcnt_reg <= tcnt_reg + 16'h0001;
          if (tcnt_reg == ADDR_CYC - 16'h0001)
          begin
            st_reg   <= S_DATA;
            tcnt_reg <= 16'h0000;
            if (wr)
            begin
              dal_reg <= input_holding_reg_reg;
              bwtbt   <= byte_wr;
              bdout   <= 1'b1;
            end
            else
            begin
              bdal_oe_d <= 1'b0;
              bwtbt     <= 1'b0;
              bdin_dma  <= 1'b1;
            end
          end
        end
        S_DATA:
        begin
          tcnt_reg <= tcnt_reg + 16'h0001;
          if (rply_f)
          begin
            st_reg   <= S_RWAIT;
            bdout    <= 1'b0;
            bdin_dma <= 1'b0;
          end
          else if (nxm_ev)
          begin
            // no reply: abandon the cycle and give the bus back
            st_reg     <= S_IDLE;
            bdout      <= 1'b0;
            bdin_dma   <= 1'b0;
            bdal_oe_d  <= 1'b0;
            bwtbt      <= 1'b0;
            bsync      <= 1'b0;
            bsack      <= 1'b0;
            busy_n_reg <= 1'b1;
          end
        end
        S_RWAIT:
        begin
          bdal_oe_d <= 1'b0;
          bwtbt     <= 1'b0;
          if (!rply_f)
            st_reg <= S_END;
        end
        S_END:
        begin
          bsync      <= 1'b0;
          busy_n_reg <= 1'b1;
          if (burst_reg && !done_ev && !user_attention_f && !ready_reg)
            st_reg <= S_HOLD;
          else
          begin
            st_reg <= S_IDLE;
            bsack  <= 1'b0;
          end
        end
        S_HOLD:
          // burst keeps the bus dedicated between requests
          if (accept)
          begin
            st_reg     <= S_ADDR;
            tcnt_reg   <= 16'h0000;
            busy_n_reg <= 1'b0;
            dal_reg    <= {ba_reg[15:1], flt_reg[`PUDMA_SY_BYTE]};
            bdal_oe_d  <= 1'b1;
            bwtbt      <= flt_reg[`PUDMA_SY_CT0];
          end
          else if (user_attention_f || ready_reg)
          begin
            st_reg <= S_IDLE;
            bsack  <= 1'b0;
          end
        default:
          st_reg <= S_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // counters, output buffer, ready and flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wc_reg <= 16'h0000;
      ba_reg <= 16'h0000;
    end
    else
    begin
      if (wc_load)
        wc_reg <= load_value;
      else if (xfer_end && cstep_reg)
        wc_reg <= wc_next;
      if (ba_load)
        ba_reg <= load_value;
      else if (xfer_end && astep_reg)
        ba_reg <= ba_reg + `PUDMA_ADDR_STEP;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      output_holding_reg_reg <= 16'h0000;
    else if (rd_load)
      output_holding_reg_reg <= dal_f;
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ready_reg  <= `PUDMA_READY_RST;
      user_attention_d_reg <= 1'b0;
    end
    else
    begin
      user_attention_d_reg <= user_attention_f;
      // terminating events win over a start in the same cycle
      if (done_ev || user_attention_ev || nxm_ev)
        ready_reg <= 1'b1;
      else if (go_start)
        ready_reg <= 1'b0;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      count_done_flag <= 1'b0;
      attention_flag  <= 1'b0;
      nxm_flag        <= 1'b0;
    end
    else
    begin
      count_done_flag <= done_ev || (count_done_flag && !flag_clear);
      attention_flag  <= user_attention_ev || (attention_flag && !flag_clear);
      nxm_flag        <= nxm_ev || (nxm_flag && !flag_clear);
    end
  end
  // ----------------------------------------------------------------
  // interrupt request and vector answer
  // ----------------------------------------------------------------
  pudma_istate_t ist_reg;
  logic          irq_reg, vec_oe_reg;
  assign iack_take = ist_reg == I_IDLE && irq_reg && din_f && iak_f;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      irq_reg <= 1'b0;
    else if (int_enable && (done_ev || user_attention_ev || nxm_ev))
      irq_reg <= 1'b1;
    else if (iack_take)
      irq_reg <= 1'b0;
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ist_reg    <= I_IDLE;
      brply_out  <= 1'b0;
      vec_oe_reg <= 1'b0;
    end
    else
    begin
      case (ist_reg)
        I_IDLE:
          if (iack_take)
          begin
            ist_reg    <= I_VEC;
            brply_out  <= 1'b1;
            vec_oe_reg <= 1'b1;
          end
        I_VEC:
          if (!din_f && !iak_f)
          begin
            ist_reg    <= I_IDLE;
            brply_out  <= 1'b0;
            vec_oe_reg <= 1'b0;
          end
        default:
          ist_reg <= I_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the vector is only driven from the acknowledge until din and iak are both gone
  assign bdal_out           = vec_oe_reg ? INT_VECTOR : dal_reg;
  assign bdal_oe            = vec_oe_reg || bdal_oe_d;
  assign bdin_out           = bdin_dma;
  assign bdin_oe            = bdin_dma;
  assign brply_oe           = brply_out;
  assign birq               = irq_reg;
  assign ready              = ready_reg;
  assign busy_n             = busy_n_reg;
  assign word_counter       = wc_reg;
  assign bus_address        = ba_reg;
  assign output_holding_reg = output_holding_reg_reg;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  localparam int REQ_LAT = 2;
  sequence seq_granted;
    st_reg == S_REQ && gnt_f;
  endsequence
  sequence seq_master;
    bsack && !bdmr;
  endsequence
  a_start_ready: assert property (go_start && !done_ev && !user_attention_ev && !nxm_ev |=> !ready)
    else $error("ready not low after start");
  a_req_busy: assert property (accept |-> ##[1:REQ_LAT] (!busy_n && (bdmr || bsack)))
    else $error("request did not drop busy and raise bus request");
  a_grant_master: assert property (seq_granted |=> seq_master)
    else $error("grant did not give mastership");
  a_write_addr: assert property ($rose(bsync) && wr |-> bwtbt && bdal_oe && !bdout)
    else $error("write address phase wrong");
  a_word_wtbt: assert property ($rose(bdout) |-> bwtbt == byte_wr && bdal_out == input_holding_reg_reg)
    else $error("data phase bwtbt or data wrong");
  a_reply_drop: assert property (st_reg == S_DATA && rply_f |=> !bdout && !bdin_out ##1 !bdal_oe)
    else $error("strobe not dropped on reply");
  a_read_addr: assert property ($rose(bdin_out) |-> bsync && !bdal_oe && !wr)
    else $error("read strobe without address phase");
  a_output_holding_reg_hold: assert property (!rd_load |=> $stable(output_holding_reg))
    else $error("output buffer changed without read");
  a_done_ready: assert property (done_ev |=> ready && busy_n)
    else $error("count done did not raise ready");
  a_nxm_abort: assert property (nxm_ev |=> !bsack && !bsync && nxm_flag)
    else $error("timeout did not abort and flag");
  a_vec_answer: assert property (iack_take |=> brply_out && !birq && bdal_out == INT_VECTOR)
    else $error("vector answer wrong");
  a_iack_end: assert property (ist_reg == I_VEC && !din_f && !iak_f |=> !brply_out)
    else $error("reply not dropped after acknowledge");
endmodule : pudma_core
`default_nettype wire

// >>> pudma_core_tb.sv
// Purpose: self-checking bench for pudma_core
// Assumes: short counts, REQ_CYC 3 and NXM_CYC 20
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module pudma_core_tb;
  import pudma_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        go_start, int_enable, flag_clear, wc_load, ba_load, mute;
  logic        cycle_request, user_attention, addr_step_allow, count_step_allow, byte_sel, burst_select_n;
  logic        cycle_type_bit0, cycle_type_bit1;
  logic [15:0] load_value, user_data_in, word_counter, bus_address, output_holding_reg;
  logic [15:0] bdal_in, bdal_out, wr_data, vec_seen, addr_seen;
  logic        count_done_flag, attention_flag, nxm_flag, ready, busy_n, bdal_oe, bdmr, bdmgi, bsack;
  logic        bsync, bwtbt, bdout, bdin_in, bdin_out, bdin_oe, brply_in, brply_out, brply_oe, birq, biaki;
  int          err_count = 0;
  int          tests_run = 0;
  always #20 mclk = ~mclk;
  pudma_core #(.REQ_CYC(16'h0003), .NXM_CYC(16'h0014)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .go_start(go_start), .int_enable(int_enable), .flag_clear(flag_clear),
    .wc_load(wc_load), .ba_load(ba_load), .load_value(load_value), .word_counter(word_counter),
    .bus_address(bus_address), .count_done_flag(count_done_flag), .attention_flag(attention_flag),
    .nxm_flag(nxm_flag), .cycle_request(cycle_request), .user_attention(user_attention),
    .addr_step_allow(addr_step_allow), .count_step_allow(count_step_allow), .byte_sel(byte_sel),
    .burst_select_n(burst_select_n), .cycle_type_bit0(cycle_type_bit0), .cycle_type_bit1(cycle_type_bit1),
    .user_data_in(user_data_in), .ready(ready), .busy_n(busy_n), .output_holding_reg(output_holding_reg),
    .bdal_in(bdal_in), .bdal_out(bdal_out), .bdal_oe(bdal_oe), .bdmr(bdmr), .bdmgi(bdmgi), .bsack(bsack),
    .bsync(bsync), .bwtbt(bwtbt), .bdout(bdout), .bdin_in(bdin_in), .bdin_out(bdin_out), .bdin_oe(bdin_oe),
    .brply_in(brply_in), .brply_out(brply_out), .brply_oe(brply_oe), .birq(birq), .biaki(biaki));
  pudma_bus_mdl i_bus (
    .mclk(mclk), .mute(mute), .bdmr(bdmr), .bsack(bsack), .bsync(bsync), .bdout(bdout), .bdin_out(bdin_out),
    .brply_out(brply_out), .birq(birq), .bdal_out(bdal_out), .bdal_oe(bdal_oe), .bdmgi(bdmgi),
    .biaki(biaki), .bdin_in(bdin_in), .brply_in(brply_in), .bdal_in(bdal_in), .wr_data(wr_data),
    .vec_seen(vec_seen), .addr_seen(addr_seen));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic setup(input logic [15:0] wc, input logic [15:0] ba);
    @(negedge mclk);
    load_value = wc;
    wc_load = 1'b1;
    flag_clear = 1'b1;
    @(negedge mclk);
    {wc_load, flag_clear} = 2'b00;
    load_value = ba;
    ba_load = 1'b1;
    @(negedge mclk);
    ba_load = 1'b0;
    go_start = 1'b1;
    @(negedge mclk);
    go_start = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : setup
  // lines settle one cycle before the request; held until busy drops
  task automatic xfer(input logic c0, input logic c1, input logic st, input logic [15:0] d);
    @(negedge mclk);
    {cycle_type_bit0, cycle_type_bit1, addr_step_allow, count_step_allow, user_data_in} = {c0, c1, st, st, d};
    @(negedge mclk);
    cycle_request = 1'b1;
    repeat (60) if (busy_n !== 1'b0) @(negedge mclk);
    cycle_request = 1'b0;
    repeat (400) if (busy_n !== 1'b1) @(negedge mclk);
    repeat (2) @(negedge mclk);
  endtask : xfer
  task automatic wrap_up;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write;
    chk({14'h0, ready, busy_n}, 16'h0003);
    setup(16'hfffe, 16'h1000);
    chk({15'h0, ready}, 16'h0000);
    xfer(1'b1, 1'b0, 1'b1, 16'h5a3c);
    chk(wr_data, 16'h5a3c);
    chk(bus_address, 16'h1002);
    chk(word_counter, 16'hffff);
    chk({14'h0, ready, busy_n}, 16'h0001);
    chk(addr_seen, 16'h1000);
    chk({10'h0, bdmr, bsync, bwtbt, bdout, bdin_oe, brply_oe}, 16'h0000);
    $display("write test done");
  endtask : t_write
  task automatic t_read;
    xfer(1'b0, 1'b0, 1'b0, 16'h0000);
    chk(output_holding_reg, 16'hc3a5);
    xfer(1'b0, 1'b1, 1'b0, 16'h0000);
    chk(output_holding_reg, 16'hc3a6);
    chk(bus_address, 16'h1002);
    chk(word_counter, 16'hffff);
    $display("read test done");
  endtask : t_read
  task automatic t_done;
    int_enable = 1'b1;
    byte_sel = 1'b1;
    xfer(1'b1, 1'b1, 1'b1, 16'h00a5);
    byte_sel = 1'b0;
    chk(wr_data, 16'h00a5);
    chk(addr_seen, 16'h1003);
    chk(word_counter, 16'h0000);
    chk({14'h0, ready, count_done_flag}, 16'h0003);
    chk(output_holding_reg, 16'hc3a6);
    repeat (60) @(negedge mclk);
    chk(vec_seen, 16'h0080);
    chk({15'h0, birq}, 16'h0000);
    xfer(1'b1, 1'b0, 1'b1, 16'h1111);
    chk(wr_data, 16'h00a5);
    $display("done test done");
  endtask : t_done
  task automatic t_nxm;
    setup(16'hfffe, 16'h2000);
    mute = 1'b1;
    xfer(1'b1, 1'b0, 1'b1, 16'h7777);
    mute = 1'b0;
    chk({15'h0, nxm_flag}, 16'h0001);
    chk({14'h0, ready, bsack}, 16'h0002);
    chk(bus_address, 16'h2000);
    $display("nxm test done");
  endtask : t_nxm
  task automatic t_user_attention;
    setup(16'hfff0, 16'h3000);
    user_attention = 1'b1;
    repeat (10) @(negedge mclk);
    chk({14'h0, ready, attention_flag}, 16'h0003);
    user_attention = 1'b0;
    $display("attention test done");
  endtask : t_user_attention
  task automatic t_burst;
    setup(16'hfffe, 16'h4000);
    burst_select_n = 1'b0;
    xfer(1'b1, 1'b0, 1'b1, 16'h1234);
    chk({14'h0, ready, bsack}, 16'h0001);
    xfer(1'b1, 1'b0, 1'b1, 16'h5678);
    burst_select_n = 1'b1;
    chk(wr_data, 16'h5678);
    chk(addr_seen, 16'h4002);
    chk(bus_address, 16'h4004);
    chk({14'h0, ready, bsack}, 16'h0002);
    $display("burst test done");
  endtask : t_burst
  initial
  begin
    {go_start, int_enable, flag_clear, wc_load, ba_load, mute, cycle_request, user_attention} = 8'h00;
    {addr_step_allow, count_step_allow, byte_sel, cycle_type_bit0, cycle_type_bit1} = 5'h00;
    burst_select_n = 1'b1;
    load_value = 16'h0000;
    user_data_in = 16'h0000;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    t_write;
    t_read;
    t_done;
    t_nxm;
    t_user_attention;
    t_burst;
    wrap_up;
  end
  initial
  begin
    #(40 * 10000);
    err_count++;
    wrap_up;
  end
endmodule : pudma_core_tb
`default_nettype wire

// >>> pudma_map.svh
// Purpose: constants for the parallel user dma bus master
// Assumes: mclk at 25 MHz
// Notes:   least times round up, the reply timeout rounds down
`ifndef PUDMA_MAP_SVH
`define PUDMA_MAP_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PUDMA_CLK_NS      40
`define PUDMA_REQ_MIN_NS  1000
`define PUDMA_ADDR_NS     250
`define PUDMA_NXM_NS      10000
`define PUDMA_REQ_CYC     ((`PUDMA_REQ_MIN_NS + `PUDMA_CLK_NS - 1) / `PUDMA_CLK_NS)
`define PUDMA_ADDR_CYC    ((`PUDMA_ADDR_NS + `PUDMA_CLK_NS - 1) / `PUDMA_CLK_NS)
`define PUDMA_NXM_CYC     (`PUDMA_NXM_NS / `PUDMA_CLK_NS)
// ----------------------------------------------------------------
// reset values and step
// ----------------------------------------------------------------
`define PUDMA_READY_RST   1'b1
`define PUDMA_BUSY_N_RST  1'b1
`define PUDMA_VECTOR      16'h0080
`define PUDMA_ADDR_STEP   16'h0002
// ----------------------------------------------------------------
// synchroniser vector field positions
// ----------------------------------------------------------------
`define PUDMA_SY_REQ      0
`define PUDMA_SY_USER_ATTENTION     1
`define PUDMA_SY_GNT      2
`define PUDMA_SY_RPLY     3
`define PUDMA_SY_DIN      4
`define PUDMA_SY_IAK      5
`define PUDMA_SY_ASTEP    6
`define PUDMA_SY_CSTEP    7
`define PUDMA_SY_BYTE     8
`define PUDMA_SY_BURSTN   9
`define PUDMA_SY_CT0      10
`define PUDMA_SY_CT1      11
`define PUDMA_SY_DAL      12
`define PUDMA_SY_UDAT     28
`define PUDMA_SY_W        44
`endif

// >>> pudma_pkg.sv
// Purpose: types for the parallel user dma bus master
// Assumes: nothing
// Notes:   cycle type code is {cycle_type_bit0, cycle_type_bit1}
package pudma_pkg;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_REQ   = 3'b001,
    S_ADDR  = 3'b010,
    S_DATA  = 3'b011,
    S_RWAIT = 3'b100,
    S_END   = 3'b101,
    S_HOLD  = 3'b110,
    S_GACK  = 3'b111
  } pudma_state_t;
  typedef enum logic [0:0] {
    I_IDLE = 1'b0,
    I_VEC  = 1'b1
  } pudma_istate_t;
  typedef enum logic [1:0] {
    CYC_DATI  = 2'b00,
    CYC_DATIO = 2'b01,
    CYC_DATO  = 2'b10,
    CYC_DATOB = 2'b11
  } pudma_cyc_t;
endpackage : pudma_pkg
